// ### hdl/tbr_top.sv
// Purpose: trace buffer readout window and line counter behind axi4-lite
// Assumes: capture logic and profiler run on aclk; por_resetn synchronous
// Notes:   window reads are only legal as full words at the window index
//
// Function
// R1 - real data only unlocked, disarmed, source set
// R2 - only aligned word reads, else 0xEE bytes
// R3 - software clears profile enable before reading
// R4 - word write unlocks when disarmed and idle
// R5 - valid read returns 16 bits, advances pointer
// R6 - arming locks buffer until unlocking write
// R7 - bad-size read returns error, pointer held
// R8 - armed or locked word read returns 0xEEEE
// R9 - stored trace kept across non power-on resets
// R10 - 7-bit count of halves reports stored lines
// R11 - rollover sets full flag, counting continues
// R12 - begin alignment at 64 lines ends session
// R13 - full with nonzero count overwrites oldest
// R14 - arming clears the line counter
// R15 - of the resets, only power-on reset clears the counter
// R16 - window reads never alter the counter
// R17 - source bit one enables tracing, zero none
// R18 - two-bit alignment: end, begin, middle
// R19 - 64-bit line read as four words
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tbr_top
   import tbr_pkg::*;
#(
   parameter int ADDR_W = TBR_ADDR_W
)(
   // clock and resets
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              por_resetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // trace capture and profiler status
   input  wire logic              cap_valid,
   input  wire logic [HALF_W-1:0] cap_data,
   input  wire logic              profiling_active_flag,
   // status out
   output logic                   session_active,
   output logic                   irq
);
   // debug control state
   logic              arm_q;        // session enable
   logic              locked_q;     // window locked
   logic              tsrc_q;       // trace_source_select
   logic [1:0]        trigger_alignment_q;     // trigger_alignment
   logic              prof_en_q;    // profile enable
   logic [PTR_W-1:0]  rd_ptr_q;     // window read pointer
   // interrupts
   logic [IRQ_W-1:0]  irq_stat_q;   // sticky events
   logic [IRQ_W-1:0]  irq_mask_q;   // enables
   logic              irq_q;        // level output
   // write channel state
   logic              awready_q;
   logic              aw_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic              wready_q;
   logic              w_got_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   // read channel state
   logic              arready_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   // combinational helpers
   logic              wr_fire;      // both halves of a write held
   logic              rd_fire;      // read address taken
   logic              wr_ctrl;      // control register write
   logic              arm_set;      // one written to session enable
   logic              arm_clr;      // zero written to session enable
   logic              cfg_ok;       // config fields writable
   logic              unlock;       // unlocking window write
   logic              win_ok;       // window returns real data
   logic              rd_win;       // aligned word read of window
   logic              rd_irqs;      // read of interrupt status
   logic              cap_en;       // capture accepted
   logic              wr_known;     // write address mapped
   logic [31:0]       rd_val;       // read mux
   logic              rd_err;       // unmapped read
   logic [IRQ_W-1:0]  evt;          // new events
   logic [IRQ_W-1:0]  irq_stat_d;   // next sticky status
   logic [WORD_W-1:0] mem_word;     // word at read pointer

   tbr_cnt_if cif ();

   assign s_axi_awready  = awready_q;
   assign s_axi_wready   = wready_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rvalid   = rvalid_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign session_active = arm_q;
   assign irq            = irq_q;

   // decode of the committed write and the accepted read
   assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
   assign rd_fire = s_axi_arvalid & arready_q;
   assign wr_ctrl = wr_fire & (awaddr_q == CTRL_ADDR) & wstrb_q[0];
   assign arm_set = wr_ctrl & wdata_q[CTRL_ARM];
   assign arm_clr = wr_ctrl & ~wdata_q[CTRL_ARM];
   assign cfg_ok  = ~arm_q & ~profiling_active_flag;
   // only a full 16-bit write at the aligned index unlocks
   assign unlock  = wr_fire & (awaddr_q == WIN_ADDR) & (&wstrb_q[1:0]) & ~arm_q
                    & ~profiling_active_flag & ~prof_en_q; // R4
   assign win_ok  = ~locked_q & ~arm_q & tsrc_q; // R1 R8
   assign rd_win  = rd_fire & (s_axi_araddr == WIN_ADDR);
   assign rd_irqs = rd_fire & (s_axi_araddr == IRQS_ADDR);
   // only writable targets answer okay; read-only ones and holes get slverr
   assign wr_known = (awaddr_q == CTRL_ADDR) | (awaddr_q == WIN_ADDR)
                     | (awaddr_q == IRQM_ADDR);

   // capture gating: source off or reserved alignment means no tracing
   assign cap_en          = arm_q & tsrc_q & (trigger_alignment_q != ALIGN_RSVD) & ~cif.stop; // R17 R18
   assign cif.half_wr     = cap_valid & cap_en;
   assign cif.clr         = arm_set; // R14
   assign cif.begin_align = (trigger_alignment_q == ALIGN_BEGIN); // R18

   tbr_cnt u_cnt (
      .aclk       (aclk),
      .por_resetn (por_resetn),
      .cif        (cif)
   );

   tbr_mem u_mem (
      .aclk    (aclk),
      .wr_en   (cif.half_wr),
      .wr_addr (cif.count),
      .wr_data (cap_data),
      .rd_ptr  (rd_ptr_q),
      .rd_data (mem_word)
   );

   // session enable; a fresh arm wins over the begin-aligned stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_q <= 1'b0;
      end else if (arm_set) begin
         arm_q <= 1'b1;
      end else if (arm_clr) begin
         arm_q <= 1'b0;
      end else if (cif.stop) begin
         arm_q <= 1'b0; // R12
      end
   end

   // lock: set by arming, released only by the unlocking write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked_q <= 1'b1;
      end else if (arm_set) begin
         locked_q <= 1'b1; // R6
      end else if (unlock) begin
         locked_q <= 1'b0; // R4 R6
      end
   end

   // config fields frozen while armed or profiling
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tsrc_q    <= 1'b0;
         trigger_alignment_q  <= ALIGN_END;
         prof_en_q <= 1'b0;
      end else if (wr_ctrl & cfg_ok) begin
         tsrc_q    <= wdata_q[CTRL_TSRC]; // R17
         trigger_alignment_q  <= wdata_q[CTRL_ALIGN +: 2]; // R18
         prof_en_q <= wdata_q[CTRL_PROF];
      end
   end

   // read pointer: starts at the oldest half on unlock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr_q <= '0;
      end else if (unlock) begin
         rd_ptr_q <= cif.full ? {cif.count, 1'b0} : '0; // R13
      end else if (rd_win & win_ok) begin
         rd_ptr_q <= rd_ptr_q + PTR_W'(1); // R5 R19
      end
   end

   // event sources; set beats the clear-on-read
   always_comb begin
      evt           = '0;
      evt[IRQ_FULL] = cif.wrap;
      evt[IRQ_END]  = cif.stop & arm_q & ~arm_set;
      irq_stat_d    = (rd_irqs ? '0 : irq_stat_q) | evt;
   end

   // sticky status and the level interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_d & irq_mask_q);
      end
   end

   // mask register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= '0;
      end else if (wr_fire & (awaddr_q == IRQM_ADDR) & wstrb_q[0]) begin
         irq_mask_q <= wdata_q[IRQ_W-1:0];
      end
   end

   // write address channel, one write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         aw_got_q  <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid & awready_q) begin
         awready_q <= 1'b0;
         aw_got_q  <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_got_q  <= 1'b0;
      end else begin
         awready_q <= ~aw_got_q & ~bvalid_q;
      end
   end

   // write data channel, may arrive before or after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b0;
         w_got_q  <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid & wready_q) begin
         wready_q <= 1'b0;
         w_got_q  <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_got_q  <= 1'b0;
      end else begin
         wready_q <= ~w_got_q & ~bvalid_q;
      end
   end

   // write response; read-only or unmapped targets get slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read mux; the upper window index stands for any misaligned access
   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      unique case (s_axi_araddr)
         WIN_ADDR: begin
            rd_val[WORD_W-1:0] = win_ok ? mem_word : ERR_WORD; // R1 R5 R8
         end
         WIN_HI_ADDR: begin
            rd_val[WORD_W-1:0] = ERR_WORD; // R2 R7
         end
         CNT_ADDR: begin
            rd_val[CNT_W-1:0] = cif.count; // R10 R16
         end
         CTRL_ADDR: begin
            rd_val[CTRL_ARM]        = arm_q;
            rd_val[CTRL_ALIGN +: 2] = trigger_alignment_q;
            rd_val[CTRL_TSRC]       = tsrc_q;
            rd_val[CTRL_PROF]       = prof_en_q;
         end
         STAT_ADDR: begin
            rd_val[STAT_FULL]  = cif.full; // R11
            rd_val[STAT_PROFILING_ACTIVE_FLAG] = profiling_active_flag;
            rd_val[STAT_LOCK]  = locked_q;
         end
         IRQS_ADDR: begin
            rd_val[IRQ_W-1:0] = irq_stat_q;
         end
         IRQM_ADDR: begin
            rd_val[IRQ_W-1:0] = irq_mask_q;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // read channel, data registered at address acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else if (rd_fire) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_val;
         rresp_q   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_q & s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end else begin
         arready_q <= ~rvalid_q;
      end
   end
endmodule
`default_nettype wire

// ### include/tbr_pkg.sv
// Purpose: shared constants for the trace buffer readout block
// Assumes: 32-bit axi4-lite data, 20 mhz aclk
// Notes:   window and count sit at index*4; the other offsets are byte addresses
`default_nettype none
package tbr_pkg;
   // bus shape
   localparam int          TBR_ADDR_W   = 14;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // register indices as printed, byte address is four times
   localparam logic [11:0] WIN_IDX      = 12'h104;
   localparam logic [11:0] WIN_HI_IDX   = 12'h105;
   localparam logic [11:0] CNT_IDX      = 12'h106;
   localparam logic [13:0] WIN_ADDR     = {WIN_IDX, 2'h0};
   localparam logic [13:0] WIN_HI_ADDR  = {WIN_HI_IDX, 2'h0};
   localparam logic [13:0] CNT_ADDR     = {CNT_IDX, 2'h0};
   // local control, status and interrupt registers
   localparam logic [13:0] CTRL_ADDR    = 14'h0400;
   localparam logic [13:0] STAT_ADDR    = 14'h0420;
   localparam logic [13:0] IRQS_ADDR    = 14'h0424;
   localparam logic [13:0] IRQM_ADDR    = 14'h0428;
   // debug_control_reg fields
   localparam int          CTRL_ARM     = 0;
   localparam int          CTRL_ALIGN   = 1;
   localparam int          CTRL_TSRC    = 3;
   localparam int          CTRL_PROF    = 4;
   // debug_status_reg fields
   localparam int          STAT_FULL    = 0;
   localparam int          STAT_PROFILING_ACTIVE_FLAG   = 1;
   localparam int          STAT_LOCK    = 2;
   // interrupt status/mask fields
   localparam int          IRQ_W        = 2;
   localparam int          IRQ_FULL     = 0;
   localparam int          IRQ_END      = 1;
   // trigger_alignment encodings
   localparam logic [1:0]  ALIGN_END    = 2'h0;
   localparam logic [1:0]  ALIGN_BEGIN  = 2'h1;
   localparam logic [1:0]  ALIGN_MID    = 2'h2;
   localparam logic [1:0]  ALIGN_RSVD   = 2'h3;
   // buffer geometry: 64 lines of 64 bits, stored as 32-bit halves
   localparam int          CNT_W        = 7;
   localparam int          HALF_W       = 32;
   localparam int          WORD_W       = 16;
   localparam int          PTR_W        = 8;
   localparam logic [15:0] ERR_WORD     = 16'heeee;
   localparam logic [6:0]  CNT_MAX      = 7'h7f;
   localparam logic [6:0]  CNT_ONE      = 7'h01;
endpackage
`default_nettype wire

// ### include/tbr_cnt_if.sv
// Purpose: carrier between readout top and line counter
// Assumes: single aclk domain
// Notes:   stop and wrap are combinational from counter state
`timescale 1ns/1ps
`default_nettype none
interface tbr_cnt_if;
   import tbr_pkg::*;
   logic             clr;          // session start, clears count
   logic             half_wr;      // one 32-bit half stored
   logic             begin_align;  // begin alignment selected
   logic [CNT_W-1:0] count;        // line_count_field
   logic             full;         // buffer_full_flag
   logic             wrap;         // count rolls over this cycle
   logic             stop;         // begin-aligned session is complete
   modport ctl (output clr, half_wr, begin_align, input count, full, wrap, stop);
   modport cnt (input clr, half_wr, begin_align, output count, full, wrap, stop);
endinterface
`default_nettype wire

// ### hdl/tbr_cnt.sv
// Purpose: line counter and buffer-full flag
// Assumes: por_resetn synchronous to aclk
// Notes:   only power-on reset and arming (clr) clear state; system reset has no effect here
`timescale 1ns/1ps
`default_nettype none
module tbr_cnt
   import tbr_pkg::*;
(
   // clock and power-on reset
   input  wire logic aclk,
   input  wire logic por_resetn,
   // control side
   tbr_cnt_if.cnt    cif
);
   logic [CNT_W-1:0] count_q;  // half-line count
   logic             full_q;   // sticky full flag

   assign cif.count = count_q;
   assign cif.full  = full_q;
   // rollover of the 7-bit count
   assign cif.wrap  = cif.half_wr & (count_q == CNT_MAX); // R11
   // 64 lines reached under begin alignment
   assign cif.stop  = cif.begin_align & full_q & (count_q == '0); // R12

   // count update, never touched by reads of the window
   always_ff @(posedge aclk) begin
      if (!por_resetn) begin
         count_q <= '0; // R15
      end else if (cif.clr) begin
         count_q <= '0; // R14
      end else if (cif.half_wr) begin
         count_q <= count_q + CNT_ONE; // R10 R16
      end
   end

   // full flag, set on rollover and kept while counting goes on
   always_ff @(posedge aclk) begin
      if (!por_resetn) begin
         full_q <= 1'b0; // R15
      end else if (cif.clr) begin
         full_q <= 1'b0;
      end else if (cif.wrap) begin
         full_q <= 1'b1; // R11 R13
      end
   end
endmodule
`default_nettype wire

// ### hdl/tbr_mem.sv
// Purpose: trace line storage, 32-bit halves, 16-bit read port
// Assumes: write address supplied by the line counter
// Notes:   no reset at all, so contents survive every reset but power-up
`timescale 1ns/1ps
`default_nettype none
module tbr_mem
   import tbr_pkg::*;
#(
   parameter int DEPTH = 128
)(
   // clock
   input  wire logic              aclk,
   // write side
   input  wire logic              wr_en,
   input  wire logic [CNT_W-1:0]  wr_addr,
   input  wire logic [HALF_W-1:0] wr_data,
   // read side
   input  wire logic [PTR_W-1:0]  rd_ptr,
   output logic      [WORD_W-1:0] rd_data
);
   logic [HALF_W-1:0] mem_q [DEPTH]; // circular storage

   // store, oldest entry overwritten on wrap
   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data; // R9 R13
      end
   end

   // pointer lsb picks the half of the 32-bit entry
   always_comb begin
      rd_data = rd_ptr[0] ? mem_q[rd_ptr[PTR_W-1:1]][HALF_W-1:WORD_W]
                          : mem_q[rd_ptr[PTR_W-1:1]][WORD_W-1:0]; // R19
   end
endmodule
`default_nettype wire

// ### tb/tbr_top_assertions.sv
// Purpose: concurrent checks on the tbr_top ports
// Assumes: one aclk domain, aresetn synchronous and active low
// Notes:   bound into tbr_top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tbr_top_assertions
   import tbr_pkg::*;
#(
   parameter int ADDR_W = TBR_ADDR_W
)(
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // write response
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   // read address and data
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   // status outputs
   input wire logic              session_active,
   input wire logic              irq
);
   // one clock, system reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // a response must stand until the master takes it
   a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped early");
   a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
      else $error("rdata not held");
   // read answer one edge after the address is taken
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready with rvalid");
   // outputs quiet out of reset
   a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !session_active && !irq)
      else $error("active after reset");
   // window errors: armed word read and misaligned read
   a_armed_error: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == WIN_ADDR
      && session_active |=> s_axi_rdata == {16'h0, ERR_WORD}) else $error("armed read gave data");
   a_misalign_error: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == WIN_HI_ADDR
      |=> s_axi_rdata == {16'h0, ERR_WORD}) else $error("misaligned read gave data");
   // count register is seven bits wide
   a_count_width: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CNT_ADDR
      |=> s_axi_rdata[31:7] == 25'h0) else $error("count upper bits set");
   // arming commits with the write response
   a_arm_commit: assert property ($rose(session_active) |-> $rose(s_axi_bvalid))
      else $error("arm without write");
endmodule

bind tbr_top tbr_top_assertions #(.ADDR_W(ADDR_W)) u_tbr_top_assertions (.aclk, .aresetn, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .session_active, .irq);
`default_nettype wire

// ### tb/tbr_top_tb_top.sv
// Purpose: self-checking bench for tbr_top
// Assumes: bench is sole bus master and capture source
// Notes:   expectations queued; a monitor compares each answer
`timescale 1ns/1ps
`default_nettype none
module tbr_top_tb_top
   import tbr_pkg::*;
;
   // clock, resets, bus, capture
   logic              aclk, aresetn, por_resetn;
   logic [13:0]       s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, cap_data;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic              cap_valid, profiling_active_flag, session_active, irq;
   // bookkeeping
   int                bad_count, num_checks;
   logic [33:0]       rq[$];          // expected {rresp, rdata}
   logic [1:0]        bq[$];          // expected bresp
   logic [31:0]       mem_ref[128];   // model of stored halves
   logic [6:0]        cnt_m;          // model of the half counter
   integer            seed = 32'hb325cf35;
   localparam logic [33:0] EERR = {RESP_OKAY, 16'h0, ERR_WORD};

   tbr_top u_tbr_top (.aclk, .aresetn, .por_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cap_valid, .cap_data, .profiling_active_flag, .session_active, .irq);

   // 20 mhz clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   function automatic logic [33:0] ok(logic [31:0] v);
      return {RESP_OKAY, v};
   endfunction

   task automatic chk(logic [33:0] got, logic [33:0] exp, string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   task automatic tmo;
      bad_count++;
      $display("wrong value at %0t: timeout", $time);
      stop_test;
   endtask

   // write: aw and w offered together, bready up until bvalid
   task automatic wr(logic [13:0] a, logic [31:0] d, logic [3:0] s = 4'h1, logic [1:0] r = RESP_OKAY);
      int n = 0;
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 100);
      s_axi_bready <= 1'b0;
      if (!s_axi_bvalid) tmo();
      @(posedge aclk);
   endtask

   // read: note queued first, monitor compares the answer
   task automatic rd(logic [13:0] a, logic [33:0] exp);
      int n = 0;
      rq.push_back(exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 100);
      s_axi_rready <= 1'b0;
      if (!s_axi_rvalid) tmo();
      @(posedge aclk);
   endtask

   // one 16-bit half of a stored entry
   task automatic win(int e, bit hi);
      rd(WIN_ADDR, ok({16'h0, hi ? mem_ref[e][31:16] : mem_ref[e][15:0]}));
   endtask

   // back-to-back halves; st: block should store them
   task automatic cap(int n, bit st);
      logic [31:0] d;
      repeat (n) begin
         d = $random(seed);
         cap_valid <= 1'b1;
         cap_data <= d;
         if (st) begin
            mem_ref[cnt_m] = d;
            cnt_m++;
         end
         @(posedge aclk);
      end
      cap_valid <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic tdone(string name);
      $display("test %s done at %0t", name, $time);
   endtask

   // monitor: oldest note against each answer
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read");
      if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()}, "bresp");
   end

   // watchdog for the whole run
   initial #5000000 tmo();

   initial begin
      {aresetn, por_resetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cap_data} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {cap_valid, profiling_active_flag} = '0;
      cnt_m = '0;
      bad_count = 0;
      num_checks = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      por_resetn <= 1'b1;
      @(posedge aclk);
      // reset state, bad sizes, unmapped place
      rd(STAT_ADDR, ok(32'h4));
      rd(CNT_ADDR, ok(32'h0));
      rd(WIN_ADDR, EERR);
      rd(WIN_HI_ADDR, EERR);
      rd(14'h0008, {RESP_SLVERR, 32'h0});
      wr(14'h0008, 32'h1, 4'hf, RESP_SLVERR);
      tdone("reset");
      // store three lines, read the first one back as words
      wr(CTRL_ADDR, 32'h9);
      cap(6, 1'b1);
      rd(CNT_ADDR, ok(32'h6));
      rd(WIN_ADDR, EERR);
      wr(CTRL_ADDR, 32'h8);
      rd(WIN_ADDR, EERR);
      wr(WIN_ADDR, 32'h0, 4'h3);
      win(0, 1'b0);
      rd(WIN_HI_ADDR, EERR);
      win(0, 1'b1);
      win(1, 1'b0);
      win(1, 1'b1);
      wr(CNT_ADDR, 32'h7f, 4'hf, RESP_SLVERR);
      rd(CNT_ADDR, ok(32'h6));
      tdone("readout");
      // unlock refused while profiling, source off gives errors
      wr(CTRL_ADDR, 32'h9);
      cnt_m = '0;
      rd(CNT_ADDR, ok(32'h0));
      cap(2, 1'b1);
      wr(CTRL_ADDR, 32'h8);
      profiling_active_flag <= 1'b1;
      rd(STAT_ADDR, ok(32'h6));
      wr(WIN_ADDR, 32'h0, 4'h3);
      profiling_active_flag <= 1'b0;
      rd(WIN_ADDR, EERR);
      wr(CTRL_ADDR, 32'h0);
      wr(WIN_ADDR, 32'h0, 4'h3);
      rd(WIN_ADDR, EERR);
      tdone("lock");
      // system reset keeps count and contents
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CNT_ADDR, ok(32'h2));
      wr(CTRL_ADDR, 32'h8);
      wr(WIN_ADDR, 32'h0, 4'h3);
      win(0, 1'b0);
      tdone("warm reset");
      // begin alignment stops at 64 lines, interrupts raised then cleared
      wr(IRQM_ADDR, 32'h3);
      wr(CTRL_ADDR, 32'hb);
      cnt_m = '0;
      cap(128, 1'b1);
      cap(2, 1'b0);
      chk({33'h0, session_active}, 34'h0, "session");
      rd(STAT_ADDR, ok(32'h5));
      rd(CNT_ADDR, ok(32'h0));
      chk({33'h0, irq}, 34'h1, "irq");
      rd(IRQS_ADDR, ok(32'h3));
      rd(IRQS_ADDR, ok(32'h0));
      repeat (2) @(posedge aclk);
      chk({33'h0, irq}, 34'h0, "irq");
      tdone("begin align");
      // end alignment keeps counting and overwrites, interrupt masked
      wr(IRQM_ADDR, 32'h0);
      wr(CTRL_ADDR, 32'h9);
      cnt_m = '0;
      cap(130, 1'b1);
      rd(CNT_ADDR, ok(32'h2));
      rd(STAT_ADDR, ok(32'h5));
      chk({33'h0, irq}, 34'h0, "irq");
      rd(IRQS_ADDR, ok(32'h1));
      wr(CTRL_ADDR, 32'h8);
      wr(WIN_ADDR, 32'h0, 4'h3);
      win(2, 1'b0);
      win(2, 1'b1);
      tdone("end align");
      stop_test;
   end
endmodule
`default_nettype wire
